// file: rtl/abx_defines.vh
// Constants for the execute datapath: register map, control fields,
// status flag positions, operation codes and cycle counts.
// Assumes inclusion by bare name from the design files.
`ifndef ABX_DEFINES_VH
`define ABX_DEFINES_VH

// Register byte offsets
`define ABX_ADDR_CTRL       8'h00
`define ABX_ADDR_OPERAND_A  8'h04
`define ABX_ADDR_OPERAND_B  8'h08
`define ABX_ADDR_FLAGS      8'h0C
`define ABX_ADDR_PC         8'h10
`define ABX_ADDR_ZPTR       8'h14
`define ABX_ADDR_OFFSET     8'h18
`define ABX_ADDR_STATE      8'h1C
`define ABX_ADDR_IO_BITS    8'h20

// Control register fields
`define ABX_CTRL_OP_MSB     5
`define ABX_CTRL_OP_LSB     0
`define ABX_CTRL_SEL_MSB    8
`define ABX_CTRL_SEL_LSB    6
`define ABX_CTRL_TWO_WORD   9
`define ABX_CTRL_LONG_PC    10

// State register fields
`define ABX_STATE_BUSY      0
`define ABX_STATE_CYC_LSB   8
`define ABX_STATE_DEPTH_LSB 12

// Status flag bit positions
`define ABX_FLAG_C          0
`define ABX_FLAG_Z          1
`define ABX_FLAG_N          2
`define ABX_FLAG_V          3
`define ABX_FLAG_S          4
`define ABX_FLAG_H          5
`define ABX_FLAG_T          6
`define ABX_FLAG_I          7

// Operation codes
`define ABX_OP_SUM              6'h00
`define ABX_OP_SUM_CARRY        6'h01
`define ABX_OP_DIFFERENCE       6'h02
`define ABX_OP_DIFFERENCE_IMMEDIATE 6'h03
`define ABX_OP_DIFFERENCE_WITH_BORROW 6'h04
`define ABX_OP_DIFFERENCE_IMMEDIATE_BORROW 6'h05
`define ABX_OP_CONJUNCTION      6'h06
`define ABX_OP_CONJUNCTION_IMM  6'h07
`define ABX_OP_DISJUNCTION      6'h08
`define ABX_OP_DISJUNCTION_IMM  6'h09
`define ABX_OP_EXCLUSIVE_DISJUNCTION 6'h0A
`define ABX_OP_SELF_CONJUNCTION_CHECK 6'h0B
`define ABX_OP_MASK_CLEAR_BITS  6'h0C
`define ABX_OP_MASK_SET_BITS    6'h0D
`define ABX_OP_ROTATE_LEFT_CARRY 6'h0E
`define ABX_OP_ROTATE_RIGHT_CARRY 6'h0F
`define ABX_OP_COMPARE_SKIP_EQUAL 6'h10
`define ABX_OP_SKIP_GPR_BIT_LOW 6'h11
`define ABX_OP_SKIP_GPR_BIT_HIGH 6'h12
`define ABX_OP_SKIP_IO_BIT_LOW  6'h13
`define ABX_OP_SKIP_IO_BIT_HIGH 6'h14
`define ABX_OP_BRANCH_FLAG_HIGH 6'h15
`define ABX_OP_BRANCH_FLAG_LOW  6'h16
`define ABX_OP_BRANCH_SIGNED_GE 6'h17
`define ABX_OP_BRANCH_SIGNED_LT 6'h18
`define ABX_OP_RELATIVE_JUMP    6'h19
`define ABX_OP_RELATIVE_CALL    6'h1A
`define ABX_OP_POINTER_JUMP     6'h1B
`define ABX_OP_POINTER_CALL     6'h1C
`define ABX_OP_SUBROUTINE_RETURN 6'h1D
`define ABX_OP_INTERRUPT_RETURN 6'h1E

// Cycle counts
`define ABX_CYC_ONE         3'd1
`define ABX_CYC_TWO         3'd2
`define ABX_CYC_THREE       3'd3
`define ABX_CYC_FOUR        3'd4

// Widths and sizes
`define ABX_PC_W            22
`define ABX_HSIZE_WORD      3'b010
`define ABX_STACK_DEPTH     8
`define ABX_CONST_ONE_PC    22'h000001
`define ABX_SKIP_SHORT      22'h000002
`define ABX_SKIP_LONG       22'h000003

`endif

// file: rtl/abx_alu.v
// Arithmetic and logic unit: result and flag update for one operation.
// Assumes operands and flags are stable; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "abx_defines.vh"

module abx_alu (
  input  wire [5:0] op_i,
  input  wire [7:0] a_i,
  input  wire [7:0] b_i,
  input  wire [7:0] flags_i,
  output reg  [7:0] res_o,
  output reg  [7:0] flags_o,
  output reg        wr_o
);

  wire       cin_add;
  wire       cin_sub;
  wire [8:0] sum9;
  wire [8:0] dif9;

  assign cin_add = (op_i == `ABX_OP_SUM_CARRY) & flags_i[`ABX_FLAG_C];
  assign cin_sub = ((op_i == `ABX_OP_DIFFERENCE_WITH_BORROW) |
                    (op_i == `ABX_OP_DIFFERENCE_IMMEDIATE_BORROW)) & flags_i[`ABX_FLAG_C];
  assign sum9 = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_add};
  assign dif9 = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_sub};

  always @* begin
    res_o   = a_i;
    flags_o = flags_i;
    wr_o    = 1'b0;
    case (op_i)
      `ABX_OP_SUM, `ABX_OP_SUM_CARRY: begin
        res_o = sum9[7:0];
        wr_o  = 1'b1;
        flags_o[`ABX_FLAG_C] = sum9[8];
        flags_o[`ABX_FLAG_H] = (a_i[3] & b_i[3]) | (b_i[3] & ~res_o[3]) | (~res_o[3] & a_i[3]);
        flags_o[`ABX_FLAG_V] = (a_i[7] & b_i[7] & ~res_o[7]) | (~a_i[7] & ~b_i[7] & res_o[7]);
        flags_o[`ABX_FLAG_Z] = (res_o == 8'h00);
        flags_o[`ABX_FLAG_N] = res_o[7];
        flags_o[`ABX_FLAG_S] = res_o[7] ^ flags_o[`ABX_FLAG_V];
      end
      `ABX_OP_DIFFERENCE, `ABX_OP_DIFFERENCE_IMMEDIATE,
      `ABX_OP_DIFFERENCE_WITH_BORROW, `ABX_OP_DIFFERENCE_IMMEDIATE_BORROW: begin
        res_o = dif9[7:0]; // [RQ1]
        wr_o  = 1'b1;
        flags_o[`ABX_FLAG_C] = dif9[8];
        flags_o[`ABX_FLAG_H] = (~a_i[3] & b_i[3]) | (b_i[3] & res_o[3]) | (res_o[3] & ~a_i[3]);
        flags_o[`ABX_FLAG_V] = (a_i[7] & ~b_i[7] & ~res_o[7]) | (~a_i[7] & b_i[7] & res_o[7]);
        // Borrow forms with carry set keep zero only across a chain of zero bytes
        flags_o[`ABX_FLAG_Z] = (res_o == 8'h00) & (~cin_sub | flags_i[`ABX_FLAG_Z]) |
                               (res_o == 8'h00) & ~(op_i[2] & ~op_i[1]); // [RQ1]
        flags_o[`ABX_FLAG_N] = res_o[7];
        flags_o[`ABX_FLAG_S] = res_o[7] ^ flags_o[`ABX_FLAG_V];
      end
      `ABX_OP_CONJUNCTION, `ABX_OP_CONJUNCTION_IMM, `ABX_OP_DISJUNCTION,
      `ABX_OP_DISJUNCTION_IMM, `ABX_OP_EXCLUSIVE_DISJUNCTION,
      `ABX_OP_SELF_CONJUNCTION_CHECK, `ABX_OP_MASK_CLEAR_BITS, `ABX_OP_MASK_SET_BITS: begin
        case (op_i)
          `ABX_OP_CONJUNCTION, `ABX_OP_CONJUNCTION_IMM: res_o = a_i & b_i; // [RQ2]
          `ABX_OP_DISJUNCTION, `ABX_OP_DISJUNCTION_IMM: res_o = a_i | b_i; // [RQ3]
          `ABX_OP_EXCLUSIVE_DISJUNCTION:                res_o = a_i ^ b_i; // [RQ3]
          `ABX_OP_SELF_CONJUNCTION_CHECK:               res_o = a_i & a_i; // [RQ4]
          `ABX_OP_MASK_CLEAR_BITS:                      res_o = a_i & ~b_i; // [RQ5]
          default:                                      res_o = a_i | b_i; // [RQ5]
        endcase
        wr_o = 1'b1;
        flags_o[`ABX_FLAG_V] = 1'b0; // [RQ2] [RQ3] [RQ4] [RQ5]
        flags_o[`ABX_FLAG_Z] = (res_o == 8'h00);
        flags_o[`ABX_FLAG_N] = res_o[7];
        flags_o[`ABX_FLAG_S] = res_o[7];
      end
      `ABX_OP_ROTATE_LEFT_CARRY: begin
        res_o = {a_i[6:0], flags_i[`ABX_FLAG_C]}; // [RQ15]
        wr_o  = 1'b1;
        flags_o[`ABX_FLAG_C] = a_i[7];
        flags_o[`ABX_FLAG_H] = a_i[3];
        flags_o[`ABX_FLAG_Z] = (res_o == 8'h00);
        flags_o[`ABX_FLAG_N] = res_o[7];
        flags_o[`ABX_FLAG_V] = res_o[7] ^ a_i[7];
      end
      `ABX_OP_ROTATE_RIGHT_CARRY: begin
        res_o = {flags_i[`ABX_FLAG_C], a_i[7:1]}; // [RQ16]
        wr_o  = 1'b1;
        flags_o[`ABX_FLAG_C] = a_i[0];
        flags_o[`ABX_FLAG_Z] = (res_o == 8'h00);
        flags_o[`ABX_FLAG_N] = res_o[7];
        flags_o[`ABX_FLAG_V] = res_o[7] ^ a_i[0];
      end
      default: begin
        res_o   = a_i;
        flags_o = flags_i;
        wr_o    = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: rtl/abx_execute.v
// Execute datapath of a small 8-bit core, reached as an AHB-Lite slave.
// Assumes one clock, a single bus master and word-wide transfers.
// Function
// RQ1 - Subtractions write difference, set six flags
// RQ2 - Conjunction stores result, updates Z N V S
// RQ3 - Disjunctions store result, update Z N V S
// RQ4 - Test conjoins register with itself, sets flags
// RQ5 - Mask clear and set update Z N V S
// RQ6 - Compare skips next instruction when equal
// RQ7 - Register bit test skips on polarity
// RQ8 - Peripheral bit test skips on polarity
// RQ9 - Flag branch loads PC plus offset plus one
// RQ10 - Signed branches test N xor V
// RQ11 - Unsigned branches test carry, equality tests zero
// RQ12 - Branches also test I, T, H, V
// RQ13 - Pointer jump loads Z, upper bits zero
// RQ14 - Pointer call pushes return, loads Z
// RQ15 - Rotate left through carry, five flags
// RQ16 - Rotate right through carry, four flags
// RQ17 - Relative jump and call with offset
// RQ18 - Returns pop PC, interrupt return sets I
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "abx_defines.vh"

module abx_execute (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  input  wire [7:0]  io_bits_i,
  output wire        busy_o
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  reg  [1:0]  state_r;
  reg  [2:0]  cnt_r;
  reg  [2:0]  last_cyc_r;
  reg  [7:0]  opa_r;
  reg  [7:0]  opb_r;
  reg  [7:0]  flags_r;
  reg  [21:0] pc_r;
  reg  [15:0] zptr_r;
  reg  [11:0] offset_r;
  reg  [2:0]  sp_r;
  reg  [3:0]  depth_r;
  reg  [21:0] stack_mem [0:`ABX_STACK_DEPTH-1];
  reg  [7:0]  sync1_r;
  reg  [7:0]  sync2_r;
  reg  [7:0]  sync3_r;
  reg  [7:0]  io_stable_r;
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg         ok_r;
  reg  [7:0]  addr_r;
  reg  [31:0] hrdata_r;

  wire        take;
  wire        start;
  wire [5:0]  op;
  wire [2:0]  sel;
  wire        two_word;
  wire        long_pc;
  wire [7:0]  alu_res;
  wire [7:0]  alu_flags;
  wire        alu_wr;
  wire [21:0] pc_inc;
  wire [21:0] k_short;
  wire [21:0] k_long;
  wire [21:0] skip_step;
  wire [21:0] stack_top;

  reg         taken;
  reg  [2:0]  cycles;
  reg  [21:0] pc_nxt;
  reg  [7:0]  flags_nxt;
  reg         push;
  reg         pop;
  reg  [31:0] rd_mux;

  // Bus request decode
  assign take        = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = ~rd_pend_r;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;
  assign busy_o      = state_r[1];

  // A control write while idle launches one operation
  assign start    = wr_pend_r & ok_r & (addr_r == `ABX_ADDR_CTRL) & state_r[0];
  assign op       = hwdata_i[`ABX_CTRL_OP_MSB:`ABX_CTRL_OP_LSB];
  assign sel      = hwdata_i[`ABX_CTRL_SEL_MSB:`ABX_CTRL_SEL_LSB];
  assign two_word = hwdata_i[`ABX_CTRL_TWO_WORD];
  assign long_pc  = hwdata_i[`ABX_CTRL_LONG_PC];

  assign pc_inc    = pc_r + `ABX_CONST_ONE_PC;
  assign k_short   = {{15{offset_r[6]}}, offset_r[6:0]};
  assign k_long    = {{10{offset_r[11]}}, offset_r};
  assign skip_step = two_word ? `ABX_SKIP_LONG : `ABX_SKIP_SHORT;
  assign stack_top = stack_mem[sp_r - 3'd1];

  abx_alu u_alu (
    .op_i    (op),
    .a_i     (opa_r),
    .b_i     (opb_r),
    .flags_i (flags_r),
    .res_o   (alu_res),
    .flags_o (alu_flags),
    .wr_o    (alu_wr)
  );

  // Program flow, cycle count and stack action for the launched operation
  always @* begin
    taken     = 1'b0;
    cycles    = `ABX_CYC_ONE;
    pc_nxt    = pc_inc;
    flags_nxt = alu_flags;
    push      = 1'b0;
    pop       = 1'b0;
    case (op)
      `ABX_OP_COMPARE_SKIP_EQUAL: taken = (opa_r == opb_r); // [RQ6]
      `ABX_OP_SKIP_GPR_BIT_LOW:   taken = ~opa_r[sel]; // [RQ7]
      `ABX_OP_SKIP_GPR_BIT_HIGH:  taken = opa_r[sel]; // [RQ7]
      `ABX_OP_SKIP_IO_BIT_LOW:    taken = ~io_stable_r[sel]; // [RQ8]
      `ABX_OP_SKIP_IO_BIT_HIGH:   taken = io_stable_r[sel]; // [RQ8]
      `ABX_OP_BRANCH_FLAG_HIGH:   taken = flags_r[sel]; // [RQ9] [RQ11] [RQ12]
      `ABX_OP_BRANCH_FLAG_LOW:    taken = ~flags_r[sel]; // [RQ9] [RQ11] [RQ12]
      `ABX_OP_BRANCH_SIGNED_GE:
        taken = ~(flags_r[`ABX_FLAG_N] ^ flags_r[`ABX_FLAG_V]); // [RQ10]
      `ABX_OP_BRANCH_SIGNED_LT:
        taken = flags_r[`ABX_FLAG_N] ^ flags_r[`ABX_FLAG_V]; // [RQ10]
      default: taken = 1'b0;
    endcase
    case (op)
      `ABX_OP_COMPARE_SKIP_EQUAL, `ABX_OP_SKIP_GPR_BIT_LOW, `ABX_OP_SKIP_GPR_BIT_HIGH,
      `ABX_OP_SKIP_IO_BIT_LOW, `ABX_OP_SKIP_IO_BIT_HIGH: begin
        flags_nxt = flags_r; // [RQ6] [RQ7] [RQ8]
        if (taken) begin
          pc_nxt = pc_r + skip_step; // [RQ6] [RQ7] [RQ8]
          cycles = two_word ? `ABX_CYC_THREE : `ABX_CYC_TWO;
        end
      end
      `ABX_OP_BRANCH_FLAG_HIGH, `ABX_OP_BRANCH_FLAG_LOW,
      `ABX_OP_BRANCH_SIGNED_GE, `ABX_OP_BRANCH_SIGNED_LT: begin
        flags_nxt = flags_r;
        if (taken) begin
          pc_nxt = pc_inc + k_short; // [RQ9] [RQ10]
          cycles = `ABX_CYC_TWO; // [RQ9]
        end
      end
      `ABX_OP_RELATIVE_JUMP: begin
        flags_nxt = flags_r;
        pc_nxt    = pc_inc + k_long; // [RQ17]
        cycles    = `ABX_CYC_TWO; // [RQ17]
      end
      `ABX_OP_RELATIVE_CALL: begin
        flags_nxt = flags_r;
        pc_nxt    = pc_inc + k_long; // [RQ17]
        push      = 1'b1; // [RQ17]
        cycles    = long_pc ? `ABX_CYC_FOUR : `ABX_CYC_THREE; // [RQ17]
      end
      `ABX_OP_POINTER_JUMP: begin
        flags_nxt = flags_r; // [RQ13]
        pc_nxt    = {6'h00, zptr_r}; // [RQ13]
        cycles    = `ABX_CYC_TWO; // [RQ13]
      end
      `ABX_OP_POINTER_CALL: begin
        flags_nxt = flags_r; // [RQ14]
        pc_nxt    = {6'h00, zptr_r}; // [RQ14]
        push      = 1'b1; // [RQ14]
        cycles    = long_pc ? `ABX_CYC_FOUR : `ABX_CYC_THREE; // [RQ14]
      end
      `ABX_OP_SUBROUTINE_RETURN, `ABX_OP_INTERRUPT_RETURN: begin
        flags_nxt = flags_r;
        if (op == `ABX_OP_INTERRUPT_RETURN) begin
          flags_nxt[`ABX_FLAG_I] = 1'b1; // [RQ18]
        end
        pc_nxt = stack_top; // [RQ18]
        pop    = 1'b1;
        cycles = long_pc ? (`ABX_CYC_FOUR + `ABX_CYC_ONE) : `ABX_CYC_FOUR; // [RQ18]
      end
      default: begin
        cycles = `ABX_CYC_ONE; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ15] [RQ16]
      end
    endcase
  end

  // Register read multiplexer
  always @* begin
    rd_mux = 32'h00000000;
    if (ok_r) begin
      case (addr_r)
        `ABX_ADDR_OPERAND_A: rd_mux = {24'h000000, opa_r};
        `ABX_ADDR_OPERAND_B: rd_mux = {24'h000000, opb_r};
        `ABX_ADDR_FLAGS:     rd_mux = {24'h000000, flags_r};
        `ABX_ADDR_PC:        rd_mux = {10'h000, pc_r};
        `ABX_ADDR_ZPTR:      rd_mux = {16'h0000, zptr_r};
        `ABX_ADDR_OFFSET:    rd_mux = {20'h00000, offset_r};
        `ABX_ADDR_STATE:     rd_mux = {16'h0000, depth_r, 1'b0, last_cyc_r, 7'h00, state_r[1]};
        `ABX_ADDR_IO_BITS:   rd_mux = {24'h000000, io_stable_r};
        default:             rd_mux = 32'h00000000;
      endcase
    end
  end

  // Bus phases: writes finish with no wait, reads insert one wait cycle
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ok_r      <= 1'b0;
      addr_r    <= 8'h00;
      hrdata_r  <= 32'h00000000;
    end else begin
      wr_pend_r <= take & hwrite_i;
      rd_pend_r <= take & ~hwrite_i;
      if (take) begin
        addr_r <= haddr_i[7:0];
        ok_r   <= (hsize_i == `ABX_HSIZE_WORD) & (haddr_i[1:0] == 2'b00) &
                  (haddr_i[31:8] == 24'h000000);
      end
      if (rd_pend_r) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Pin synchroniser: change accepted once second and third stages agree
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r     <= 8'h00;
      sync2_r     <= 8'h00;
      sync3_r     <= 8'h00;
      io_stable_r <= 8'h00;
    end else begin
      sync1_r <= io_bits_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        io_stable_r <= sync3_r;
      end
    end
  end

  // Return address stack storage
  always @(posedge clk_i) begin
    if (start & push) begin
      stack_mem[sp_r] <= pc_inc; // [RQ14] [RQ17]
    end
  end

  // Architectural state, sequencing and software writes
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 3'd0;
      last_cyc_r <= 3'd0;
      opa_r      <= 8'h00;
      opb_r      <= 8'h00;
      flags_r    <= 8'h00;
      pc_r       <= 22'h000000;
      zptr_r     <= 16'h0000;
      offset_r   <= 12'h000;
      sp_r       <= 3'd0;
      depth_r    <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            pc_r       <= pc_nxt;
            flags_r    <= flags_nxt;
            last_cyc_r <= cycles;
            if (alu_wr && (op != `ABX_OP_SELF_CONJUNCTION_CHECK)) begin
              opa_r <= alu_res; // [RQ1] [RQ2] [RQ3] [RQ5] [RQ15] [RQ16]
            end
            if (push) begin
              sp_r <= sp_r + 3'd1;
              if (depth_r != 4'h8) begin
                depth_r <= depth_r + 4'h1;
              end
            end
            if (pop) begin
              sp_r <= sp_r - 3'd1;
              if (depth_r != 4'h0) begin
                depth_r <= depth_r - 4'h1;
              end
            end
            if (cycles != `ABX_CYC_ONE) begin
              cnt_r   <= cycles - 3'd1;
              state_r <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          cnt_r <= cnt_r - 3'd1;
          if (cnt_r == 3'd1) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (wr_pend_r && ok_r) begin
        case (addr_r)
          `ABX_ADDR_OPERAND_A: opa_r    <= hwdata_i[7:0];
          `ABX_ADDR_OPERAND_B: opb_r    <= hwdata_i[7:0];
          `ABX_ADDR_FLAGS:     flags_r  <= hwdata_i[7:0];
          `ABX_ADDR_PC:        pc_r     <= hwdata_i[21:0];
          `ABX_ADDR_ZPTR:      zptr_r   <= hwdata_i[15:0];
          `ABX_ADDR_OFFSET:    offset_r <= hwdata_i[11:0];
          default: begin
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: sim/abx_execute_chk.sv
// Checker for the execute block: bus timing, response code and cycle counts.
// Assumes only the ports of abx_execute, one clock and word-wide transfers.
`timescale 1ns/100ps
`default_nettype none
module abx_execute_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        busy_o
);
  logic       acc;
  logic       rd_q;
  logic       ctl_q;
  logic       go;
  logic [5:0] op;
  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign op  = hwdata_i[5:0];
  assign go  = ctl_q & ~busy_o;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_q  <= 1'h0;
      ctl_q <= 1'h0;
    end else begin
      rd_q  <= acc & ~hwrite_i;
      ctl_q <= acc & hwrite_i & (haddr_i == 32'h0) & (hsize_i == 3'h2);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_resp_okay: assert property (hresp_o == 1'h0)
    else $error("response not OKAY");
  a_read_wait: assert property (acc & ~hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read data phase not one wait state");
  a_write_nowait: assert property (acc & hwrite_i |=> hreadyout_o)
    else $error("write data phase stalled");
  a_rdata_hold: assert property (!$past(rd_q) |-> $stable(hrdata_o))
    else $error("read data changed without a read");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(go))
    else $error("busy without a launched operation");
  a_alu_single: assert property (go && op <= 6'h0F |=> !busy_o)
    else $error("arithmetic or logic op took more than one cycle");
  a_jump_two: assert property (go && (op == 6'h19 || op == 6'h1B) |=> busy_o ##1 !busy_o)
    else $error("jump did not take two cycles");
  a_call_short: assert property (go && (op == 6'h1A || op == 6'h1C) && !hwdata_i[10]
    |=> busy_o[*2] ##1 !busy_o)
    else $error("short call did not take three cycles");
  a_ret_long: assert property (go && (op == 6'h1D || op == 6'h1E) && hwdata_i[10]
    |=> busy_o[*4] ##1 !busy_o)
    else $error("long return did not take five cycles");
  a_branch_len: assert property (go && op >= 6'h15 && op <= 6'h18
    |=> (!busy_o) or (busy_o ##1 !busy_o))
    else $error("branch took more than two cycles");
  a_skip_len: assert property (go && op >= 6'h10 && op <= 6'h14 && !hwdata_i[9]
    |=> (!busy_o) or (busy_o ##1 !busy_o))
    else $error("one-word skip took more than two cycles");
  a_busy_bound: assert property (busy_o[*4] |=> !busy_o)
    else $error("busy longer than four cycles");
endmodule
bind abx_execute abx_execute_chk chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .busy_o(busy_o));
`default_nettype wire

// file: sim/abx_io_model.sv
// Peripheral side model: presents the I/O bit lines read by the skip tests.
// Assumes the bench sets the level; lines change just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module abx_io_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] level_i,
  output var  logic [7:0] io_bits_o
);
  initial io_bits_o = 8'h00;
  always @(posedge clk_i) begin
    io_bits_o <= level_i;
  end
endmodule
`default_nettype wire

// file: sim/alu_branch_execute_tb_top.sv
// Testbench: drives the execute block over its register bus and checks results.
// Assumes the register map, op codes and cycle counts of the hand-over.
`timescale 1ns/100ps
`default_nettype none
`include "abx_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t got %0h expected %0h", $time, g, e); end end
module alu_branch_execute_tb_top;
  localparam logic [21:0] PCI = 22'h3F0100, P1 = 22'h3F0101, P2 = 22'h3F0102;
  localparam logic [21:0] P3 = 22'h3F0103, PJ = 22'h3F00F1, PZ = 22'h00ABCD;
  logic        clk_i    = 1'h0;
  logic        resetn_i = 1'h0;
  logic        hsel_i   = 1'h0;
  logic [31:0] haddr_i  = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [7:0]  io_lvl   = 8'h00;
  logic [7:0]  fb;
  logic [31:0] d;
  wire  [31:0] hrdata_o;
  wire         hreadyout_o;
  wire         busy_o;
  wire  [7:0]  io_bits;
  int          n_fail   = 0;
  int          n_tests  = 0;
  int          cyc      = 0;
  abx_execute dut_u (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (`ABX_HSIZE_WORD),
    .hwdata_i    (hwdata_i),
    .hready_i    (hreadyout_o),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (),
    .io_bits_i   (io_bits),
    .busy_o      (busy_o)
  );
  abx_io_model io_u (.clk_i(clk_i), .level_i(io_lvl), .io_bits_o(io_bits));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task rdy;
    do @(posedge clk_i); while (hreadyout_o !== 1'h1);
    d = hrdata_o;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_i   <= 1'h1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    rdy;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    rdy;
  endtask
  task idle;
    do xfer(0, `ABX_ADDR_STATE, 32'h0); while (d[0] !== 1'h0);
  endtask
  function logic [31:0] cw(input logic [5:0] op, input logic [2:0] s, input logic tw, lg);
    cw = {21'h0, lg, tw, s, op};
  endfunction
  task run(input logic [31:0] c, input logic [7:0] a, b, f, ea, ef,
           input logic [21:0] pc, input logic [2:0] n);
    xfer(1, `ABX_ADDR_OPERAND_A, {24'h0, a});
    xfer(1, `ABX_ADDR_OPERAND_B, {24'h0, b});
    xfer(1, `ABX_ADDR_FLAGS, {24'h0, f});
    xfer(1, `ABX_ADDR_PC, {10'h0, PCI});
    xfer(1, `ABX_ADDR_CTRL, c);
    idle;
    xfer(0, `ABX_ADDR_OPERAND_A, 32'h0);
    `CHK(d, {24'h0, ea})
    xfer(0, `ABX_ADDR_FLAGS, 32'h0);
    `CHK(d, {24'h0, ef})
    xfer(0, `ABX_ADDR_PC, 32'h0);
    `CHK(d, {10'h0, pc})
    xfer(0, `ABX_ADDR_STATE, 32'h0);
    `CHK(d[10:8], n)
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'h1;
    xfer(0, `ABX_ADDR_PC, 32'h0);
    `CHK(d, 32'h0)
    xfer(1, 8'h24, 32'hFFFFFFFF);
    xfer(0, 8'h24, 32'h0);
    `CHK(d, 32'h0)
    xfer(1, `ABX_ADDR_OFFSET, 32'h00000FF0);
    xfer(1, `ABX_ADDR_ZPTR, 32'h0000ABCD);
    $display("test registers done");
    run(cw(6'h02, 0, 0, 0), 8'h10, 8'h01, 8'hC0, 8'h0F, 8'hE0, P1, 1);
    run(cw(6'h03, 0, 0, 0), 8'h05, 8'h05, 8'h00, 8'h00, 8'h02, P1, 1);
    run(cw(6'h04, 0, 0, 0), 8'h00, 8'h00, 8'h01, 8'hFF, 8'h35, P1, 1);
    run(cw(6'h05, 0, 0, 0), 8'h80, 8'h00, 8'h03, 8'h7F, 8'h38, P1, 1);
    run(cw(6'h06, 0, 0, 0), 8'hF0, 8'h8F, 8'h0F, 8'h80, 8'h15, P1, 1);
    run(cw(6'h07, 0, 0, 0), 8'h0F, 8'hF0, 8'h00, 8'h00, 8'h02, P1, 1);
    run(cw(6'h08, 0, 0, 0), 8'h01, 8'h80, 8'h20, 8'h81, 8'h34, P1, 1);
    run(cw(6'h09, 0, 0, 0), 8'h00, 8'h00, 8'h08, 8'h00, 8'h02, P1, 1);
    run(cw(6'h0A, 0, 0, 0), 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h03, P1, 1);
    run(cw(6'h0B, 0, 0, 0), 8'h80, 8'h00, 8'h00, 8'h80, 8'h14, P1, 1);
    run(cw(6'h0C, 0, 0, 0), 8'hFF, 8'h0F, 8'h00, 8'hF0, 8'h14, P1, 1);
    run(cw(6'h0D, 0, 0, 0), 8'h00, 8'h01, 8'h02, 8'h01, 8'h00, P1, 1);
    run(cw(6'h0E, 0, 0, 0), 8'h80, 8'h00, 8'h10, 8'h00, 8'h1B, P1, 1);
    run(cw(6'h0F, 0, 0, 0), 8'h01, 8'h00, 8'h01, 8'h80, 8'h05, P1, 1);
    $display("test arithmetic done");
    run(cw(6'h10, 0, 0, 0), 8'h33, 8'h33, 8'h55, 8'h33, 8'h55, P2, 2);
    run(cw(6'h10, 0, 1, 0), 8'h33, 8'h33, 8'h55, 8'h33, 8'h55, P3, 3);
    run(cw(6'h10, 0, 0, 0), 8'h33, 8'h34, 8'h55, 8'h33, 8'h55, P1, 1);
    run(cw(6'h11, 3, 0, 0), 8'hF7, 8'hF7, 8'h55, 8'hF7, 8'h55, P2, 2);
    run(cw(6'h12, 3, 0, 0), 8'hF7, 8'hF7, 8'h55, 8'hF7, 8'h55, P1, 1);
    run(cw(6'h12, 7, 1, 0), 8'hF7, 8'hF7, 8'h55, 8'hF7, 8'h55, P3, 3);
    io_lvl <= 8'h04;
    repeat (8) @(posedge clk_i);
    xfer(0, `ABX_ADDR_IO_BITS, 32'h0);
    `CHK(d, 32'h00000004)
    run(cw(6'h13, 2, 0, 0), 8'h00, 8'h00, 8'h55, 8'h00, 8'h55, P1, 1);
    run(cw(6'h14, 2, 0, 0), 8'h00, 8'h00, 8'h55, 8'h00, 8'h55, P2, 2);
    run(cw(6'h13, 0, 0, 0), 8'h00, 8'h00, 8'h55, 8'h00, 8'h55, P2, 2);
    $display("test skips done");
    for (int i = 0; i < 8; i++) begin
      fb = 8'h01 << i;
      run(cw(6'h15, i[2:0], 0, 0), 0, 0, fb, 0, fb, PJ, 2);
      run(cw(6'h16, i[2:0], 0, 0), 0, 0, fb, 0, fb, P1, 1);
      run(cw(6'h16, i[2:0], 0, 0), 0, 0, ~fb, 0, ~fb, PJ, 2);
    end
    run(cw(6'h17, 0, 0, 0), 0, 0, 8'h0C, 0, 8'h0C, PJ, 2);
    run(cw(6'h17, 0, 0, 0), 0, 0, 8'h08, 0, 8'h08, P1, 1);
    run(cw(6'h18, 0, 0, 0), 0, 0, 8'h0C, 0, 8'h0C, P1, 1);
    run(cw(6'h18, 0, 0, 0), 0, 0, 8'h04, 0, 8'h04, PJ, 2);
    $display("test branches done");
    run(cw(6'h19, 0, 0, 0), 0, 0, 8'h55, 0, 8'h55, PJ, 2);
    run(cw(6'h1A, 0, 0, 0), 0, 0, 8'h55, 0, 8'h55, PJ, 3);
    run(cw(6'h1D, 0, 0, 0), 0, 0, 8'h55, 0, 8'h55, P1, 4);
    run(cw(6'h1B, 0, 0, 0), 0, 0, 8'h55, 0, 8'h55, PZ, 2);
    run(cw(6'h1C, 0, 0, 1), 0, 0, 8'h55, 0, 8'h55, PZ, 4);
    run(cw(6'h1E, 0, 0, 1), 0, 0, 8'h00, 0, 8'h80, P1, 5);
    xfer(1, `ABX_ADDR_PC, 32'h00000010);
    xfer(1, `ABX_ADDR_CTRL, cw(6'h1A, 0, 0, 0));
    idle;
    xfer(1, `ABX_ADDR_CTRL, cw(6'h1D, 0, 0, 0));
    xfer(1, `ABX_ADDR_CTRL, cw(6'h19, 0, 0, 0));
    idle;
    xfer(0, `ABX_ADDR_PC, 32'h0);
    `CHK(d, 32'h00000011)
    $display("test calls done");
    wrap_up;
  end
endmodule
`default_nettype wire
